// ### hdl/pid_top.v
// Interrupt controller with 45 request channels and four micro DMA channels
//
// Notes on behaviour
// - Mode 000 copies fixed source to destination, then destination rises by size.
// - Mode 001 copies fixed source to destination, then destination falls by size.
// - Mode 010 copies source to fixed destination, then source rises by size.
// - Mode 011 copies source to fixed destination, then source falls by size.
// - Mode 100 copies between two fixed addresses; only the count drops.
// - Size 00 byte, 01 word, 10 four bytes; zero count raises transfer complete.
// - Addresses move after the transfer; each transfer uses the old address.
// - 45 channels, each with request flag, level and start-vector routing.
// - Flag clears on reset, vector take, clear port and DMA acceptance.
// - Levels 1 to 6 are live; level 0 or 7 blocks the source.
// - Non-maskable pin and watchdog channels always run at level 7.
// - Equal levels resolve to the lowest vector first.
// - Bits 3 and 7 of each level register read the request flags.
// - Only the highest pending request and its vector go to the CPU.
// - Accept only above the mask or at level 7; acceptance sets mask to level plus one, capped at 7.
// - Return from interrupt restores the stacked mask.
// - Four start vectors route a source to micro DMA instead of service.
// - Simultaneous DMA requests serve the lowest channel first.
// - A DMA request competes at level 6 whatever the source level.
// - Zero count clears the channel start vector.
`include "pid_defs.vh"

module pid_top (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [44:0] req_in,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_q,
    input  wire        cr_wr,
    input  wire        cr_rd,
    input  wire [1:0]  cr_ch,
    input  wire [1:0]  cr_sel,
    input  wire [31:0] cr_wdata,
    output reg  [31:0] cr_rdata_q,
    output reg         irq_req_q,
    output reg  [2:0]  irq_level_q,
    output reg  [7:0]  irq_vector_q,
    input  wire        irq_take,
    input  wire        return_from_interrupt,
    output reg  [2:0]  cpu_level_mask_q,
    output wire        mem_rd_req,
    output wire [23:0] mem_rd_addr,
    output wire [1:0]  mem_rd_size,
    input  wire        mem_rd_ack,
    input  wire [31:0] mem_rd_data,
    output wire        mem_wr_req,
    output wire [23:0] mem_wr_addr,
    output wire [1:0]  mem_wr_size,
    output wire [31:0] mem_wr_data,
    input  wire        mem_wr_ready,
    output reg  [3:0]  transfer_complete_irq_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_CNT  = 2'h2;

    reg  [44:0]  flag_q;
    reg  [2:0]   lvl_q [0:44];
    reg  [7:0]   svec_q [0:3];
    reg  [31:0]  channel_source_pointer_q [0:3];
    reg  [31:0]  channel_dest_pointer_q [0:3];
    reg  [15:0]  channel_remaining_count_q [0:3];
    reg  [4:0]   channel_transfer_mode_q [0:3];
    reg  [2:0]   stk_q [0:7];
    reg  [3:0]   sp_q;
    reg  [1:0]   st_q;
    reg  [1:0]   cur_q;
    wire [44:0]  flag_set;
    wire [44:0]  flag_clr;
    wire [44:0]  routed;
    wire [134:0] elig_lvl;
    wire [179:0] match;
    wire [3:0]   dma_pend;
    wire         clr_wr;
    wire         dma_go;
    wire [2:0]   cur_mode;
    wire [1:0]   cur_size;
    wire [31:0]  step;
    wire [15:0]  cnt_dec;
    wire         fifo_in_ready;
    wire         fifo_push;
    wire [57:0]  fifo_out;
    reg  [1:0]   pick;
    reg  [2:0]   best_lvl;
    reg  [5:0]   best_idx;
    reg          found;
    reg  [7:0]   rd_mux;
    integer      j;
    integer      k;
    integer      jr;
    integer      kp;
    integer      ks;

    assign clr_wr   = reg_wr && (reg_addr == `PID_CLR_ADDR);
    assign cur_mode = channel_transfer_mode_q[cur_q][4:2];
    assign cur_size = channel_transfer_mode_q[cur_q][1:0];
    assign cnt_dec  = channel_remaining_count_q[cur_q] - 16'h0001;

    // Per-channel flag, level, routing and eligible level
    genvar gi;
    genvar gk;
    generate
        for (gi = 0; gi < `PID_NCH; gi = gi + 1) begin : g_ch
            localparam integer VI  = gi + 1;
            localparam integer LAI = `PID_LVL_BASE + gi / 2;
            localparam integer NIB = gi % 2;
            wire [2:0] eff;
            for (gk = 0; gk < `PID_NDMA; gk = gk + 1) begin : g_m
                // Start-vector match of this channel on DMA channel gk
                assign match[gk*45+gi] = (svec_q[gk] == VI[7:0]);
            end
            assign routed[gi] = match[gi] | match[45+gi] | match[90+gi] | match[135+gi];
            if (gi == 44) begin : g_tc3
                assign flag_set[gi] = req_in[gi] | transfer_complete_irq_q[3];
            end else if (gi >= `PID_TC_CH0) begin : g_tc
                assign flag_set[gi] = req_in[gi] | transfer_complete_irq_q[gi-41];
            end else begin : g_pl
                assign flag_set[gi] = req_in[gi];
            end
            // Clear by vector take, clear port or DMA acceptance
            assign flag_clr[gi] = (irq_take && irq_vector_q == VI[7:0])
                                | (clr_wr && reg_wdata == VI[7:0])
                                | (dma_go && match[pick*45+gi]);
            // Fixed top level for the non-maskable pair, 0 and 7 block
            assign eff = (gi == `PID_NMI_CH || gi == `PID_WDT_CH) ? `PID_LVL_FIXED
                       : (lvl_q[gi] == `PID_LVL_FIXED) ? `PID_LVL_OFF : lvl_q[gi];
            assign elig_lvl[gi*3 +: 3] = (flag_q[gi] && !routed[gi]) ? eff : `PID_LVL_OFF;

            // Request flag: set wins over clear
            always @(posedge ref_clk) begin
                if (rst) begin
                    flag_q[gi] <= 1'b0;
                end else begin
                    flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~flag_clr[gi]);
                end
            end

            // Level setting field in its nibble
            always @(posedge ref_clk) begin
                if (rst) begin
                    lvl_q[gi] <= `PID_LVL_OFF;
                end else if (reg_wr && reg_addr == LAI[7:0]) begin
                    lvl_q[gi] <= reg_wdata[NIB*4 +: 3];
                end
            end
        end
        for (gk = 0; gk < `PID_NDMA; gk = gk + 1) begin : g_pend
            assign dma_pend[gk] = |(flag_q & match[gk*45 +: 45]);
        end
    endgenerate

    // Highest level wins, ties to the lowest vector
    always @* begin
        best_lvl = `PID_LVL_OFF;
        best_idx = 6'h00;
        found    = 1'b0;
        for (j = 44; j >= 0; j = j - 1) begin
            if (elig_lvl[j*3 +: 3] != `PID_LVL_OFF && elig_lvl[j*3 +: 3] >= best_lvl) begin
                best_lvl = elig_lvl[j*3 +: 3];
                best_idx = j[5:0];
                found    = 1'b1;
            end
        end
    end

    // Lowest numbered DMA channel first
    always @* begin
        pick = 2'h0;
        for (kp = 3; kp >= 0; kp = kp - 1) begin
            if (dma_pend[kp]) begin
                pick = kp[1:0];
            end
        end
    end

    // DMA competes at level 6 against the mask
    assign dma_go = (st_q == ST_IDLE) && (|dma_pend) && (cpu_level_mask_q < `PID_LVL_DMA);

    // Forward request, level and vector to the CPU
    always @(posedge ref_clk) begin
        if (rst) begin
            irq_req_q    <= 1'b0;
            irq_level_q  <= `PID_LVL_OFF;
            irq_vector_q <= 8'h00;
        end else begin
            irq_req_q    <= found && !irq_take && (best_lvl > cpu_level_mask_q
                                                   || best_lvl == `PID_LVL_FIXED);
            irq_level_q  <= best_lvl;
            irq_vector_q <= {2'b00, best_idx} + 8'h01;
        end
    end

    // Level mask with save stack
    always @(posedge ref_clk) begin
        if (rst) begin
            cpu_level_mask_q <= `PID_MASK_RST;
            sp_q             <= 4'h0;
        end else if (irq_take && irq_req_q) begin
            stk_q[sp_q[2:0]] <= cpu_level_mask_q;
            if (sp_q != `PID_STK_DEPTH) begin
                sp_q <= sp_q + 4'h1;
            end
            cpu_level_mask_q <= (irq_level_q == `PID_LVL_FIXED) ? `PID_LVL_FIXED
                              : irq_level_q + 3'h1;
        end else if (return_from_interrupt && sp_q != 4'h0) begin
            cpu_level_mask_q <= stk_q[sp_q[2:0] - 3'h1];
            sp_q             <= sp_q - 4'h1;
        end
    end

    // Start vectors: software sets, terminal count clears
    always @(posedge ref_clk) begin
        if (rst) begin
            for (ks = 0; ks < `PID_NDMA; ks = ks + 1) begin
                svec_q[ks] <= 8'h00;
            end
        end else begin
            for (ks = 0; ks < `PID_NDMA; ks = ks + 1) begin
                if (reg_wr && reg_addr == `PID_SVEC_BASE + ks[7:0]) begin
                    svec_q[ks] <= reg_wdata;
                end else if (st_q == ST_CNT && cur_q == ks[1:0] && cnt_dec == 16'h0000) begin
                    svec_q[ks] <= 8'h00;
                end
            end
        end
    end

    // Register read mux with live flags in bits 3 and 7
    always @* begin
        rd_mux = 8'h00;
        for (jr = 0; jr < `PID_NCH; jr = jr + 1) begin
            if (reg_addr == `PID_LVL_BASE + jr[8:1]) begin
                rd_mux[(jr%2)*4 +: 4] = {flag_q[jr], lvl_q[jr]};
            end
        end
        for (jr = 0; jr < `PID_NDMA; jr = jr + 1) begin
            if (reg_addr == `PID_SVEC_BASE + jr[7:0]) begin
                rd_mux = svec_q[jr];
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
            cr_rdata_q  <= 32'h00000000;
        end else begin
            if (reg_rd) begin
                reg_rdata_q <= rd_mux;
            end
            if (cr_rd) begin
                case (cr_sel)
                    `PID_CR_SRC: cr_rdata_q <= channel_source_pointer_q[cr_ch];
                    `PID_CR_DST: cr_rdata_q <= channel_dest_pointer_q[cr_ch];
                    `PID_CR_CNT: cr_rdata_q <= {16'h0000, channel_remaining_count_q[cr_ch]};
                    default:     cr_rdata_q <= {27'h0, channel_transfer_mode_q[cr_ch]};
                endcase
            end
        end
    end

    // Transfer size in bytes
    assign step = (cur_size == `PID_SZ_BYTE) ? 32'h00000001
                : (cur_size == `PID_SZ_WORD) ? 32'h00000002 : 32'h00000004;

    // Read side issues only while the buffer can take the word
    assign mem_rd_req  = (st_q == ST_READ) && fifo_in_ready;
    assign mem_rd_addr = channel_source_pointer_q[cur_q][23:0];
    assign mem_rd_size = cur_size;
    assign fifo_push   = mem_rd_req && mem_rd_ack;

    // Engine state and channel registers
    always @(posedge ref_clk) begin
        if (rst) begin
            st_q                    <= ST_IDLE;
            cur_q                   <= 2'h0;
            transfer_complete_irq_q <= 4'h0;
            for (k = 0; k < `PID_NDMA; k = k + 1) begin
                channel_source_pointer_q[k]  <= `PID_PTR_RST;
                channel_dest_pointer_q[k]    <= `PID_PTR_RST;
                channel_remaining_count_q[k] <= `PID_CNT_RST;
                channel_transfer_mode_q[k]   <= `PID_MODE_RST;
            end
        end else begin
            transfer_complete_irq_q <= 4'h0;
            case (st_q)
                ST_IDLE: begin
                    if (dma_go) begin
                        cur_q <= pick;
                        case (channel_transfer_mode_q[pick][4:2])
                            `PID_M_CNT: st_q <= ST_CNT;
                            `PID_M_DINC, `PID_M_DDEC, `PID_M_SINC, `PID_M_SDEC,
                            `PID_M_FIX: st_q <= ST_READ;
                            default:    st_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_READ: begin
                    if (fifo_push) begin
                        // Pointers move after the old values were used
                        case (cur_mode)
                            `PID_M_DINC: channel_dest_pointer_q[cur_q] <=
                                channel_dest_pointer_q[cur_q] + step;
                            `PID_M_DDEC: channel_dest_pointer_q[cur_q] <=
                                channel_dest_pointer_q[cur_q] - step;
                            `PID_M_SINC: channel_source_pointer_q[cur_q] <=
                                channel_source_pointer_q[cur_q] + step;
                            `PID_M_SDEC: channel_source_pointer_q[cur_q] <=
                                channel_source_pointer_q[cur_q] - step;
                            default: st_q <= ST_CNT;
                        endcase
                        st_q <= ST_CNT;
                    end
                end
                ST_CNT: begin
                    if (cur_mode == `PID_M_CNT) begin
                        channel_source_pointer_q[cur_q] <=
                            channel_source_pointer_q[cur_q] + 32'h00000001;
                    end
                    channel_remaining_count_q[cur_q] <= cnt_dec;
                    if (cnt_dec == 16'h0000) begin
                        transfer_complete_irq_q[cur_q] <= 1'b1;
                    end
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
            // Control-register load port, low five mode bits kept
            if (cr_wr) begin
                case (cr_sel)
                    `PID_CR_SRC: channel_source_pointer_q[cr_ch] <= cr_wdata;
                    `PID_CR_DST: channel_dest_pointer_q[cr_ch] <= cr_wdata;
                    `PID_CR_CNT: channel_remaining_count_q[cr_ch] <= cr_wdata[15:0];
                    default:     channel_transfer_mode_q[cr_ch] <= cr_wdata[4:0];
                endcase
            end
        end
    end

    // Buffer between read and write sides; write port stalls it
    pid_fifo #(
        .W     (`PID_FIFO_W),
        .DEPTH (`PID_FIFO_DEPTH),
        .AW    (`PID_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   ({cur_size, channel_dest_pointer_q[cur_q][23:0], mem_rd_data}),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (mem_wr_req),
        .out_ready (mem_wr_ready)
    );

    assign mem_wr_size = fifo_out[57:56];
    assign mem_wr_addr = fifo_out[55:32];
    assign mem_wr_data = fifo_out[31:0];
endmodule // pid_top

// ### hdl/pid_defs.vh
// Shared constants for the prioritised interrupt controller with micro DMA
`ifndef PID_DEFS_VH
`define PID_DEFS_VH

// Channel counts
`define PID_NCH         45
`define PID_NDMA        4
`define PID_TC_CH0      41
`define PID_NMI_CH      0
`define PID_WDT_CH      1

// Special-register map on the 8-bit register port
`define PID_LVL_BASE    8'h90
`define PID_SVEC_BASE   8'hC0
`define PID_CLR_ADDR    8'hC8

// Priority levels
`define PID_LVL_OFF     3'h0
`define PID_LVL_FIXED   3'h7
`define PID_LVL_DMA     3'h6
`define PID_MASK_RST    3'h0
`define PID_STK_DEPTH   8

// Control-register selectors on the load port
`define PID_CR_SRC      2'h0
`define PID_CR_DST      2'h1
`define PID_CR_CNT      2'h2
`define PID_CR_MODE     2'h3

// Transfer mode field, bits 4:2 of the mode register
`define PID_M_DINC      3'h0
`define PID_M_DDEC      3'h1
`define PID_M_SINC      3'h2
`define PID_M_SDEC      3'h3
`define PID_M_FIX       3'h4
`define PID_M_CNT       3'h5

// Transfer size field, bits 1:0 of the mode register
`define PID_SZ_BYTE     2'h0
`define PID_SZ_WORD     2'h1
`define PID_SZ_QUAD     2'h2

// Reset values of the per-channel registers
`define PID_PTR_RST     32'h00000000
`define PID_CNT_RST     16'h0000
`define PID_MODE_RST    5'h00

// Data buffer in the transfer path: size, destination address, data
`define PID_FIFO_DEPTH  16
`define PID_FIFO_AW     4
`define PID_FIFO_W      58

`endif

// ### hdl/pid_fifo.v
// Parameterised flip-flop FIFO with valid/ready on both sides
module pid_fifo #(
    parameter W     = 58,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg  [W-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0] wr_ptr_q;
    reg  [AW-1:0] rd_ptr_q;
    reg  [AW:0]   fill_q;
    wire          push;
    wire          pop;

    // Honest full and empty from the fill count
    assign in_ready  = (fill_q != DEPTH);
    assign out_valid = (fill_q != 0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    // Storage write
    always @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            fill_q   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                fill_q <= fill_q + 1'b1;
            end else if (pop && !push) begin
                fill_q <= fill_q - 1'b1;
            end
        end
    end
endmodule // pid_fifo

// ### verif/pid_top_monitor.sv
// Assertion checker on the controller's CPU and memory ports
module pid_top_monitor (
    input logic        ref_clk,
    input logic        rst,
    input logic        irq_take,
    input logic        return_from_interrupt,
    input logic        irq_req_q,
    input logic [2:0]  irq_level_q,
    input logic [7:0]  irq_vector_q,
    input logic [2:0]  cpu_level_mask_q,
    input logic        mem_rd_req,
    input logic        mem_rd_ack,
    input logic [23:0] mem_rd_addr,
    input logic        mem_wr_req,
    input logic        mem_wr_ready,
    input logic [23:0] mem_wr_addr,
    input logic [31:0] mem_wr_data,
    input logic [3:0]  transfer_complete_irq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Forwarded request must beat the mask unless non-maskable
    above_mask_a: assert property (
        irq_req_q |-> irq_level_q == 3'h7 || irq_level_q > cpu_level_mask_q)
        else $error("forwarded request not above mask");
    live_level_a: assert property (irq_req_q |-> irq_level_q != 3'h0)
        else $error("request forwarded at blocked level");
    nmi_level_a: assert property (
        irq_req_q && irq_vector_q <= 8'h02 |-> irq_level_q == 3'h7)
        else $error("fixed source not at level 7");
    // Acceptance raises the mask and withdraws the request
    take_mask_a: assert property (
        irq_take && irq_req_q |=> cpu_level_mask_q ==
            ($past(irq_level_q) == 3'h7 ? 3'h7 : $past(irq_level_q) + 3'h1))
        else $error("mask not level plus one after take");
    take_drop_a: assert property (irq_take && irq_req_q |=> !irq_req_q)
        else $error("request still up after take");
    mask_hold_a: assert property (
        !$past(rst) && !$past(irq_take) && !$past(return_from_interrupt)
            |-> $stable(cpu_level_mask_q))
        else $error("mask moved without take or return");
    // Completion is a single-cycle pulse
    done_pulse_a: assert property (
        |transfer_complete_irq_q |=> transfer_complete_irq_q == 4'h0)
        else $error("complete pulse longer than one cycle");
    // Memory requests hold until answered
    rd_hold_a: assert property (
        mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
        else $error("read request dropped or moved");
    wr_hold_a: assert property (
        mem_wr_req && !mem_wr_ready |=> mem_wr_req && $stable(mem_wr_addr)
            && $stable(mem_wr_data))
        else $error("write request dropped or moved");
endmodule // pid_top_monitor

// ### verif/pid_mem_model.sv
// Memory and I/O space answering the engine's reads and writes
module pid_mem_model (
    input  logic        ref_clk,
    input  logic        rst,
    input  logic        slow,
    input  logic        mem_rd_req,
    input  logic [23:0] mem_rd_addr,
    output logic        mem_rd_ack,
    output logic [31:0] mem_rd_data,
    input  logic        mem_wr_req,
    output logic        mem_wr_ready
);
    logic [1:0]  wait_q;
    logic [31:0] last_q;
    logic        tgl_q;

    // Wait states when slow; last word kept so the idle bus can show its inverse
    always @(posedge ref_clk) begin
        if (rst || !mem_rd_req || mem_rd_ack)
            wait_q <= 2'h0;
        else
            wait_q <= wait_q + 2'h1;
        last_q <= rst ? 32'h0 : (mem_rd_ack ? mem_rd_data : last_q);
        tgl_q <= rst ? 1'h0 : ~tgl_q;
    end

    // Read answers carry a tag byte above the address
    assign mem_rd_ack   = mem_rd_req && (!slow || wait_q == 2'h2);
    assign mem_rd_data  = mem_rd_ack ? {8'h5A, mem_rd_addr} : ~last_q;
    assign mem_wr_ready = !slow || tgl_q;
endmodule // pid_mem_model

// ### verif/pid_top_tb.sv
// Self-checking bench for the interrupt controller and micro DMA engine
`include "pid_defs.vh"
module pid_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic        cr_wr = 1'h0, cr_rd = 1'h0, slow = 1'h0;
    logic        irq_take = 1'h0, return_from_interrupt = 1'h0;
    logic [44:0] req_in = '0;
    logic [7:0]  reg_addr = '0, reg_wdata = '0, reg_rdata_q, irq_vector_q;
    logic [1:0]  cr_ch = '0, cr_sel = '0, mem_rd_size, mem_wr_size;
    logic [31:0] cr_wdata = '0, cr_rdata_q, mem_rd_data, mem_wr_data, v, mk;
    logic [23:0] mem_rd_addr, mem_wr_addr;
    logic [2:0]  irq_level_q, cpu_level_mask_q;
    logic [3:0]  transfer_complete_irq_q;
    logic        irq_req_q, mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ready;
    logic [25:0] wr_q[$];
    logic [31:0] wd_q[$];
    int          mismatches = 0, num_checks = 0, tc_cnt = 0;
    int          sz, st, ds, dd, e, t0, rs = 3;

    always #25 ref_clk = ~ref_clk;
    pid_top i_dut (.*);
    pid_mem_model i_mem (.*);

    // Log accepted writes and completion pulses
    always @(posedge ref_clk) begin
        if (mem_wr_req && mem_wr_ready) begin
            wr_q.push_back({mem_wr_size, mem_wr_addr});
            wd_q.push_back(mem_wr_data);
        end
        if (mem_rd_ack)
            rs = mem_rd_size;
        tc_cnt += $countones(transfer_complete_irq_q);
    end

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One access on the register port or the control-register load port
    task automatic acc(bit cr, bit wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d[7:0];
        {cr_ch, cr_sel} <= a[3:0];
        cr_wdata <= d;
        {reg_wr, reg_rd, cr_wr, cr_rd} <= {!cr && wr, !cr && !wr, cr && wr, cr && !wr};
        @(posedge ref_clk);
        {reg_wr, reg_rd, cr_wr, cr_rd} <= 4'h0;
        #1 q = cr ? cr_rdata_q : {24'h0, reg_rdata_q};
    endtask
    task automatic rchk(bit cr, logic [7:0] a, logic [31:0] ex, string n);
        acc(cr, 1'h0, a, 32'h0, v);
        check(n, v, ex);
    endtask
    task automatic pulse(logic [44:0] m);
        @(posedge ref_clk);
        req_in <= m;
        @(posedge ref_clk);
        req_in <= '0;
        tick(3);
    endtask
    task automatic cpu(bit ret);
        @(posedge ref_clk);
        irq_take <= !ret;
        return_from_interrupt <= ret;
        @(posedge ref_clk);
        {irq_take, return_from_interrupt} <= 2'h0;
        tick(3);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        tick(6);
        rst <= 1'h0;
        rchk(1'h0, 8'h90, 32'h0, "level0");
        rchk(1'h1, 8'h03, 32'h0, "mode0");
        $display("test reset done");
        // Levels, readback of flags, tiebreak, mask and clearing
        acc(1'h0, 1'h1, 8'h92, 32'h03, v);
        acc(1'h0, 1'h1, 8'h93, 32'h03, v);
        pulse(45'hD0);
        rchk(1'h0, 8'h93, 32'h8B, "flags67");
        check("fwd4", {irq_req_q, irq_level_q, irq_vector_q}, 32'hB05);
        cpu(1'h0);
        check("mask4", cpu_level_mask_q, 32'h4);
        check("held", irq_req_q, 32'h0);
        cpu(1'h1);
        check("unmask", cpu_level_mask_q, 32'h0);
        check("fwd6", {irq_req_q, irq_level_q, irq_vector_q}, 32'hB07);
        acc(1'h0, 1'h1, `PID_CLR_ADDR, 32'h07, v);
        rchk(1'h0, 8'h93, 32'h83, "clr6");
        check("lvl0", irq_req_q, 32'h0);
        acc(1'h0, 1'h1, 8'h93, 32'h70, v);
        tick(3);
        check("lvl7", irq_req_q, 32'h0);
        acc(1'h0, 1'h1, `PID_CLR_ADDR, 32'h08, v);
        for (int i = 0; i < 2; i++) begin
            pulse(45'h1 << i);
            check("nmi", {irq_req_q, irq_level_q, irq_vector_q}, 32'hF01 + i);
            cpu(1'h0);
            check("mask7", cpu_level_mask_q, 32'h7);
            cpu(1'h1);
        end
        $display("test interrupts done");
        // Every mode and size, two triggers from source channel 10
        for (int m = 0; m < 7; m++) begin
            sz = m % 3;
            st = (m == 5) ? 1 : 1 << sz;
            ds = (m == 2 || m == 5) ? st : (m == 3 ? -st : 0);
            dd = (m == 0) ? st : (m == 1 ? -st : 0);
            e = (m < 6) ? 0 : 2;
            mk = (32'h1 << (8 << sz)) - 32'h1;
            slow <= m[0];
            wr_q.delete();
            wd_q.delete();
            acc(1'h1, 1'h1, 8'h00, 32'h1000, v);
            acc(1'h1, 1'h1, 8'h01, 32'h2000, v);
            acc(1'h1, 1'h1, 8'h02, 32'h2, v);
            acc(1'h1, 1'h1, 8'h03, {27'h0, m[2:0], sz[1:0]}, v);
            acc(1'h0, 1'h1, `PID_SVEC_BASE, 32'h0B, v);
            t0 = tc_cnt;
            repeat (2) pulse(45'h400);
            v = '1;
            for (int i = 0; i < 40 && v[15:0] !== e[15:0]; i++)
                acc(1'h1, 1'h0, 8'h02, 32'h0, v);
            tick(3);
            rchk(1'h1, 8'h00, 32'h1000 + 2 * ds, "src");
            rchk(1'h1, 8'h01, 32'h2000 + 2 * dd, "dst");
            rchk(1'h1, 8'h02, e, "count");
            check("writes", wr_q.size(), (m < 5) ? 2 : 0);
            if (m < 5) begin
                check("waddr", wr_q[1], {sz[1:0], 24'h2000 + dd[23:0]});
                check("rsize", rs, sz);
                check("wdata", wd_q[1] & mk, {8'h5A, 24'h1000 + ds[23:0]} & mk);
            end
            check("done", tc_cnt - t0, m < 6);
            rchk(1'h0, `PID_SVEC_BASE, (m < 6) ? 32'h0 : 32'h0B, "svec");
            rchk(1'h0, 8'hA4, (m < 6) ? 32'h80 : 32'h0, "flag41");
            rchk(1'h0, 8'h95, 32'h0, "flag10");
            acc(1'h0, 1'h1, `PID_CLR_ADDR, 32'h2A, v);
        end
        $display("test modes done");
        // Two channels triggered together; channel 0 serves source 12
        slow <= 1'h0;
        wr_q.delete();
        for (int c = 0; c < 2; c++) begin
            acc(1'h1, 1'h1, {4'h0, c[1:0], 2'h1}, 32'h3000 + c, v);
            acc(1'h1, 1'h1, {4'h0, c[1:0], 2'h2}, 32'h1, v);
            acc(1'h1, 1'h1, {4'h0, c[1:0], 2'h3}, 32'h10, v);
            acc(1'h0, 1'h1, 8'hC0 + c[7:0], 32'h0D - 2 * c, v);
        end
        t0 = tc_cnt;
        pulse(45'h1400);
        for (int i = 0; i < 40 && wr_q.size() < 2; i++)
            tick(1);
        tick(3);
        check("first", wr_q[0], 32'h3000);
        check("second", wr_q[1], 32'h3001);
        check("both", tc_cnt - t0, 32'h2);
        $display("test channel order done");
        stop_test();
    end
endmodule // pid_top_tb

bind pid_top pid_top_monitor i_mon (.*);
